// >>> hw/perf_mon_pkg.sv
// Constants shared by the port traffic monitor
`default_nettype none
package perf_mon_pkg;
   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 8;
   localparam int DEPTH_W = 8;
   localparam int PRESC_W = 16;
   localparam int IRQ_W   = 3;
   // Byte offsets
   localparam logic [7:0] OFS_STAT_CTRL = 8'h00;
   localparam logic [7:0] OFS_CNT0      = 8'h04;
   localparam logic [7:0] OFS_CNT1      = 8'h08;
   localparam logic [7:0] OFS_TX_CFG    = 8'h0C;
   localparam logic [7:0] OFS_TX_OCC    = 8'h10;
   localparam logic [7:0] OFS_TX_PER    = 8'h14;
   localparam logic [7:0] OFS_RX_CFG    = 8'h18;
   localparam logic [7:0] OFS_RX_OCC    = 8'h1C;
   localparam logic [7:0] OFS_RX_PER    = 8'h20;
   localparam logic [7:0] OFS_REORD     = 8'h24;
   localparam logic [7:0] OFS_REORD_THR = 8'h28;
   localparam logic [7:0] OFS_STATUS    = 8'h2C;
   localparam logic [7:0] OFS_MASK      = 8'h30;
   // Counter control slice layout
   localparam int CTRL_SLICE_W  = 8;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_DIR_BIT  = 2;
   localparam int CTRL_PRIO_LSB = 3;
   localparam logic [1:0] MODE_WORDS = 2'h0;
   localparam logic [1:0] MODE_PKTS  = 2'h1;
   localparam logic [1:0] MODE_PRIO  = 2'h2;
   // Watermark config layout
   localparam int WM_LVL_LSB  = 0;
   localparam int WM_LIM_LSB  = 8;
   localparam int WM_GRAN_LSB = 16;
   localparam int WM_GRAN_W   = 4;
   localparam int WM_PW_BIT   = 20;
   // Status bits
   localparam int ST_TX_WM = 0;
   localparam int ST_RX_WM = 1;
   localparam int ST_REORD = 2;
   // Reset values
   localparam logic [31:0] STAT_CTRL_RST = 32'h0000_0303;
   localparam logic [31:0] WM_CFG_RST    = 32'h0000_FFFF;
   localparam logic [31:0] REORD_THR_RST = 32'h0000_0000;
   localparam logic [2:0]  MASK_RST      = 3'h0;
endpackage
`default_nettype wire

// >>> hw/sat_counter.sv
// Saturating event counter with clear and load
`timescale 1ns/1ps
`default_nettype none
module sat_counter #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // Control
   input  wire logic             inc_i,
   input  wire logic             clr_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] load_val_i,
   // Value
   output logic      [WIDTH-1:0] count_o
);
   logic [WIDTH-1:0] next_count;
   wire logic        at_max = &count_o;
   wire logic [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};

   // Clear keeps a coincident event
   always_comb begin
      if (load_i) begin
         next_count = load_val_i;
      end else if (clr_i) begin
         next_count = inc_i ? one : '0;
      end else if (inc_i && !at_max) begin
         next_count = count_o + one;
      end else begin
         next_count = count_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) count_o <= '0;
      else         count_o <= next_count;
   end

   chk_sat_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      at_max && inc_i && !clr_i && !load_i |=> &count_o)
      else $error("counter wrapped");
   chk_clr_event: assert property (@(posedge clk_i) disable iff (reset_i)
      clr_i && inc_i && !load_i |=> count_o == one)
      else $error("event lost on clear");
endmodule
`default_nettype wire

// >>> hw/wm_monitor.sv
// Queue depth watermark monitor for one direction
`timescale 1ns/1ps
`default_nettype none
module wm_monitor (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // Queue and config
   input  wire logic [7:0]  depth_i,
   input  wire logic [31:0] cfg_i,
   // Register access
   input  wire logic        occ_clr_i,
   input  wire logic        per_clr_i,
   input  wire logic        occ_load_i,
   input  wire logic        per_load_i,
   input  wire logic [31:0] load_val_i,
   // Results
   output logic             above_o,
   output logic             limit_evt_o,
   output logic [31:0]      occ_o,
   output logic [31:0]      per_o
);
   logic                    above_q;
   logic [15:0]             presc;
   wire logic [7:0]  lvl  = cfg_i[perf_mon_pkg::WM_LVL_LSB +: 8];
   wire logic [7:0]  lim  = cfg_i[perf_mon_pkg::WM_LIM_LSB +: 8];
   wire logic [3:0]  gran = cfg_i[perf_mon_pkg::WM_GRAN_LSB +: perf_mon_pkg::WM_GRAN_W];
   wire logic [15:0] top  = (16'h0001 << gran) - 16'h0001;
   wire logic        rise = above_o && !above_q;
   wire logic        tick = above_o && (presc == top);
   wire logic [31:0] occ_base = occ_clr_i ? 32'h0000_0000 : occ_o;

   // Above the mark when the depth is strictly greater than the level field
   assign above_o     = depth_i > lvl;
   assign limit_evt_o = rise && !occ_load_i && (occ_base == {24'h000000, lim});

   // Prescaler restarts each episode; sub-tick residue is dropped
   always_ff @(posedge clk_i) begin
      if (reset_i)       presc <= '0;
      else if (!above_o) presc <= '0;
      else if (tick)     presc <= '0;
      else               presc <= presc + 16'h0001;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) above_q <= 1'b0;
      else         above_q <= above_o;
   end

   sat_counter #(.WIDTH(32)) u_occ (.clk_i(clk_i), .reset_i(reset_i), .inc_i(rise),
      .clr_i(occ_clr_i), .load_i(occ_load_i), .load_val_i(load_val_i), .count_o(occ_o));
   sat_counter #(.WIDTH(32)) u_per (.clk_i(clk_i), .reset_i(reset_i), .inc_i(tick),
      .clr_i(per_clr_i), .load_i(per_load_i), .load_val_i(load_val_i), .count_o(per_o));

   chk_occ_count: assert property (@(posedge clk_i) disable iff (reset_i)
      rise && !occ_clr_i && !occ_load_i && !(&occ_o) |=> occ_o == $past(occ_o) + 32'h1)
      else $error("occurrence not counted");
   chk_period_tick: assert property (@(posedge clk_i) disable iff (reset_i)
      above_o && gran == 4'h1 && presc == 16'h0 && !per_clr_i && !per_load_i && !(&per_o)
      ##1 above_o && gran == 4'h1 && !per_clr_i && !per_load_i
      |=> per_o == $past(per_o, 2) + 32'h1)
      else $error("period tick wrong");
endmodule
`default_nettype wire

// >>> hw/port_traffic_perf_monitor.sv
// Per-port traffic statistics and congestion monitor
`timescale 1ns/1ps
`default_nettype none
module port_traffic_perf_monitor (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // Register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // Transmit link events
   input  wire logic        tx_word_i,
   input  wire logic        tx_pkt_done_i,
   input  wire logic        tx_pkt_retry_i,
   input  wire logic [1:0]  tx_pkt_prio_i,
   // Receive link events
   input  wire logic        rx_word_i,
   input  wire logic        rx_pkt_done_i,
   input  wire logic        rx_pkt_retry_i,
   input  wire logic [1:0]  rx_pkt_prio_i,
   // Queues and fabric
   input  wire logic [7:0]  tx_queue_depth_i,
   input  wire logic [7:0]  rx_queue_depth_i,
   input  wire logic        reorder_i,
   // Notifications
   output logic             irq_o,
   output logic             port_write_o,
   output logic             tx_congested_o,
   output logic             rx_congested_o
);
   // ------------------------------------------------------------
   // Configuration state
   // ------------------------------------------------------------
   logic [31:0] stat_ctrl;
   logic [31:0] tx_cfg;
   logic [31:0] rx_cfg;
   logic [31:0] reord_thr;
   logic [2:0]  irq_mask;
   logic [2:0]  irq_status;
   logic [2:0]  next_status;
   logic [31:0] next_rdata;

   // ------------------------------------------------------------
   // Counter values
   // ------------------------------------------------------------
   logic [31:0] stat_cnt [2];
   logic [1:0]  stat_inc;
   logic [31:0] tx_occ;
   logic [31:0] tx_per;
   logic [31:0] rx_occ;
   logic [31:0] rx_per;
   logic [31:0] reord_cnt;
   logic        tx_above;
   logic        rx_above;
   logic        tx_lim_evt;
   logic        rx_lim_evt;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // Read strobes also drive clear-on-read
   wire logic rd_cnt0   = rd_i && addr_i == perf_mon_pkg::OFS_CNT0;
   wire logic rd_cnt1   = rd_i && addr_i == perf_mon_pkg::OFS_CNT1;
   wire logic rd_tx_occ = rd_i && addr_i == perf_mon_pkg::OFS_TX_OCC;
   wire logic rd_tx_per = rd_i && addr_i == perf_mon_pkg::OFS_TX_PER;
   wire logic rd_rx_occ = rd_i && addr_i == perf_mon_pkg::OFS_RX_OCC;
   wire logic rd_rx_per = rd_i && addr_i == perf_mon_pkg::OFS_RX_PER;
   wire logic rd_reord  = rd_i && addr_i == perf_mon_pkg::OFS_REORD;
   wire logic rd_status = rd_i && addr_i == perf_mon_pkg::OFS_STATUS;

   // Write strobes per register
   wire logic wr_ctrl   = wr_i && addr_i == perf_mon_pkg::OFS_STAT_CTRL;
   wire logic wr_cnt0   = wr_i && addr_i == perf_mon_pkg::OFS_CNT0;
   wire logic wr_cnt1   = wr_i && addr_i == perf_mon_pkg::OFS_CNT1;
   wire logic wr_tx_cfg = wr_i && addr_i == perf_mon_pkg::OFS_TX_CFG;
   wire logic wr_tx_occ = wr_i && addr_i == perf_mon_pkg::OFS_TX_OCC;
   wire logic wr_tx_per = wr_i && addr_i == perf_mon_pkg::OFS_TX_PER;
   wire logic wr_rx_cfg = wr_i && addr_i == perf_mon_pkg::OFS_RX_CFG;
   wire logic wr_rx_occ = wr_i && addr_i == perf_mon_pkg::OFS_RX_OCC;
   wire logic wr_rx_per = wr_i && addr_i == perf_mon_pkg::OFS_RX_PER;
   wire logic wr_reord  = wr_i && addr_i == perf_mon_pkg::OFS_REORD;
   wire logic wr_thr    = wr_i && addr_i == perf_mon_pkg::OFS_REORD_THR;
   wire logic wr_mask   = wr_i && addr_i == perf_mon_pkg::OFS_MASK;

   wire logic [1:0] rd_cnt = {rd_cnt1, rd_cnt0};
   wire logic [1:0] wr_cnt = {wr_cnt1, wr_cnt0};

   // ------------------------------------------------------------
   // Packet qualification
   // ------------------------------------------------------------
   // A retried packet is not a delivered packet
   wire logic tx_pkt_ok = tx_pkt_done_i && !tx_pkt_retry_i;
   wire logic rx_pkt_ok = rx_pkt_done_i && !rx_pkt_retry_i;

   // ------------------------------------------------------------
   // Statistics counters
   // ------------------------------------------------------------
   // Private counter set for this port instance
   for (genvar i = 0; i < 2; i++) begin : g_stat
      wire logic [7:0] slice = stat_ctrl[i*perf_mon_pkg::CTRL_SLICE_W +: 8];
      wire logic [1:0] mode  = slice[perf_mon_pkg::CTRL_MODE_LSB +: 2];
      wire logic       dir   = slice[perf_mon_pkg::CTRL_DIR_BIT];
      wire logic [1:0] prio  = slice[perf_mon_pkg::CTRL_PRIO_LSB +: 2];
      wire logic       w_ev  = dir ? rx_word_i : tx_word_i;
      wire logic       p_ev  = dir ? rx_pkt_ok : tx_pkt_ok;
      wire logic [1:0] p_pri = dir ? rx_pkt_prio_i : tx_pkt_prio_i;
      wire logic       by_w  = mode == perf_mon_pkg::MODE_WORDS && w_ev;
      wire logic       by_p  = mode == perf_mon_pkg::MODE_PKTS && p_ev;
      wire logic       by_q  = mode == perf_mon_pkg::MODE_PRIO && p_ev && p_pri == prio;

      assign stat_inc[i] = by_w || by_p || by_q;

      sat_counter #(
         .WIDTH      (32)
      ) u_cnt (
         .clk_i      (clk_i),
         .reset_i    (reset_i),
         .inc_i      (stat_inc[i]),
         .clr_i      (rd_cnt[i]),
         .load_i     (wr_cnt[i]),
         .load_val_i (wdata_i),
         .count_o    (stat_cnt[i])
      );
   end

   // ------------------------------------------------------------
   // Watermark monitors
   // ------------------------------------------------------------
   // Outbound queue
   wm_monitor u_tx_wm (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .depth_i     (tx_queue_depth_i),
      .cfg_i       (tx_cfg),
      .occ_clr_i   (rd_tx_occ),
      .per_clr_i   (rd_tx_per),
      .occ_load_i  (wr_tx_occ),
      .per_load_i  (wr_tx_per),
      .load_val_i  (wdata_i),
      .above_o     (tx_above),
      .limit_evt_o (tx_lim_evt),
      .occ_o       (tx_occ),
      .per_o       (tx_per)
   );

   // Inbound queue
   wm_monitor u_rx_wm (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .depth_i     (rx_queue_depth_i),
      .cfg_i       (rx_cfg),
      .occ_clr_i   (rd_rx_occ),
      .per_clr_i   (rd_rx_per),
      .occ_load_i  (wr_rx_occ),
      .per_load_i  (wr_rx_per),
      .load_val_i  (wdata_i),
      .above_o     (rx_above),
      .limit_evt_o (rx_lim_evt),
      .occ_o       (rx_occ),
      .per_o       (rx_per)
   );

   // ------------------------------------------------------------
   // Reorder counter and threshold
   // ------------------------------------------------------------
   // Compare against the value after any same-cycle clear
   wire logic [31:0] reord_base = rd_reord ? 32'h0000_0000 : reord_cnt;
   wire logic [31:0] reord_plus = reord_base + 32'h0000_0001;
   wire logic        reord_hit  = reorder_i && !wr_reord && !(&reord_base)
                                  && reord_plus == reord_thr;

   sat_counter #(
      .WIDTH      (32)
   ) u_reord (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .inc_i      (reorder_i),
      .clr_i      (rd_reord),
      .load_i     (wr_reord),
      .load_val_i (wdata_i),
      .count_o    (reord_cnt)
   );

   // ------------------------------------------------------------
   // Sticky status
   // ------------------------------------------------------------
   // New events win over the read that clears
   wire logic [2:0] evt_vec = {reord_hit, rx_lim_evt, tx_lim_evt};
   assign next_status = (rd_status ? 3'h0 : irq_status) | evt_vec;

   wire logic tx_pw_en = tx_cfg[perf_mon_pkg::WM_PW_BIT];
   wire logic rx_pw_en = rx_cfg[perf_mon_pkg::WM_PW_BIT];
   wire logic pw_evt   = (tx_lim_evt && tx_pw_en) || (rx_lim_evt && rx_pw_en);

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   // Writable settings
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         stat_ctrl <= perf_mon_pkg::STAT_CTRL_RST;
         tx_cfg    <= perf_mon_pkg::WM_CFG_RST;
         rx_cfg    <= perf_mon_pkg::WM_CFG_RST;
         reord_thr <= perf_mon_pkg::REORD_THR_RST;
         irq_mask  <= perf_mon_pkg::MASK_RST;
      end else begin
         if (wr_ctrl)   stat_ctrl <= wdata_i;
         if (wr_tx_cfg) tx_cfg    <= wdata_i;
         if (wr_rx_cfg) rx_cfg    <= wdata_i;
         if (wr_thr)    reord_thr <= wdata_i;
         if (wr_mask)   irq_mask  <= wdata_i[2:0];
      end
   end

   // Status and notification outputs
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_status   <= 3'h0;
         irq_o        <= 1'b0;
         port_write_o <= 1'b0;
      end else begin
         irq_status   <= next_status;
         irq_o        <= |(next_status & irq_mask);
         port_write_o <= pw_evt;
      end
   end

   // Congestion flags for the arbiters, one cycle late
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tx_congested_o <= 1'b0;
         rx_congested_o <= 1'b0;
      end else begin
         tx_congested_o <= tx_above;
         rx_congested_o <= rx_above;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // Unmapped offsets read as zero
   always_comb begin
      case (addr_i)
         perf_mon_pkg::OFS_STAT_CTRL: next_rdata = stat_ctrl;
         perf_mon_pkg::OFS_CNT0:      next_rdata = stat_cnt[0];
         perf_mon_pkg::OFS_CNT1:      next_rdata = stat_cnt[1];
         perf_mon_pkg::OFS_TX_CFG:    next_rdata = tx_cfg;
         perf_mon_pkg::OFS_TX_OCC:    next_rdata = tx_occ;
         perf_mon_pkg::OFS_TX_PER:    next_rdata = tx_per;
         perf_mon_pkg::OFS_RX_CFG:    next_rdata = rx_cfg;
         perf_mon_pkg::OFS_RX_OCC:    next_rdata = rx_occ;
         perf_mon_pkg::OFS_RX_PER:    next_rdata = rx_per;
         perf_mon_pkg::OFS_REORD:     next_rdata = reord_cnt;
         perf_mon_pkg::OFS_REORD_THR: next_rdata = reord_thr;
         perf_mon_pkg::OFS_STATUS:    next_rdata = {29'h0, irq_status};
         perf_mon_pkg::OFS_MASK:      next_rdata = {29'h0, irq_mask};
         default:                     next_rdata = 32'h0000_0000;
      endcase
   end

   // Data valid only in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (reset_i)   rdata_o <= 32'h0000_0000;
      else if (rd_i) rdata_o <= next_rdata;
      else           rdata_o <= 32'h0000_0000;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   chk_read_returns: assert property (rd_cnt0 |=>
      rdata_o == $past(stat_cnt[0]))
      else $error("read value wrong");
   chk_read_clears: assert property (rd_cnt0 && !stat_inc[0] |=>
      stat_cnt[0] == 32'h0)
      else $error("read did not clear");
   chk_read_keeps_evt: assert property (rd_cnt0 && stat_inc[0] |=>
      stat_cnt[0] == 32'h1)
      else $error("event lost on read");
   chk_retry_ignored: assert property (
      g_stat[0].mode != perf_mon_pkg::MODE_WORDS && !g_stat[0].dir
      && tx_pkt_retry_i |-> !stat_inc[0])
      else $error("retry counted");
   chk_word_counted: assert property (
      g_stat[0].mode == perf_mon_pkg::MODE_WORDS && !g_stat[0].dir && tx_word_i
      && !rd_cnt0 && !wr_cnt0 && !(&stat_cnt[0])
      |=> stat_cnt[0] == $past(stat_cnt[0]) + 32'h1)
      else $error("word not counted");
   chk_prio_filter: assert property (
      g_stat[1].mode == perf_mon_pkg::MODE_PRIO && g_stat[1].p_pri != g_stat[1].prio
      |-> !stat_inc[1])
      else $error("wrong priority counted");
   chk_reorder_irq: assert property (
      reord_hit && irq_mask[perf_mon_pkg::ST_REORD] && !wr_mask
      |=> irq_o && irq_status[perf_mon_pkg::ST_REORD])
      else $error("reorder irq missing");
   chk_pw_pulse: assert property (
      tx_lim_evt && tx_pw_en |=> port_write_o
      ##1 (!port_write_o || $past(tx_lim_evt || rx_lim_evt)))
      else $error("port-write missing");
   // With port-write off in both directions there must be no port-write notification
   chk_pw_disabled: assert property (
      !tx_pw_en && !rx_pw_en |=> !port_write_o)
      else $error("port-write while disabled");
   chk_status_sticky: assert property (
      irq_status[perf_mon_pkg::ST_TX_WM] && !rd_status
      |=> irq_status[perf_mon_pkg::ST_TX_WM])
      else $error("status dropped");
   chk_congest_flag: assert property (
      tx_queue_depth_i > tx_cfg[7:0] |=> tx_congested_o)
      else $error("congestion flag missing");

   cov_read_with_evt: cover property (rd_cnt0 && stat_inc[0]);
   cov_reorder_irq: cover property (reord_hit ##1 irq_o);
   cov_port_write: cover property (port_write_o);
   cov_rx_limit: cover property (rx_lim_evt);
   cov_prio_count: cover property (g_stat[0].by_q);
endmodule
`default_nettype wire

// >>> dv/port_traffic_perf_monitor_tb.sv
// Self-checking bench for the port traffic monitor
`timescale 1ns/1ps
`default_nettype none
module port_traffic_perf_monitor_tb;
   // ------------------------------------------
   // Stimulus and result signals
   // ------------------------------------------
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr_s = 1'b0, rd_s = 1'b0, pend = 1'b0, reo = 1'b0;
   logic        txw = 1'b0, txd = 1'b0, txr = 1'b0, rxw = 1'b0, rxd = 1'b0, rxr = 1'b0;
   logic [1:0]  txp = 2'h0, rxp = 2'h0;
   logic [7:0]  txq = 8'h00, rxq = 8'h00;
   logic [31:0] rdata_o;
   logic        irq_o, port_write_o, tx_congested_o, rx_congested_o;
   logic [31:0] exp_q[$];
   logic [7:0]  adr_q[$];
   logic [2:0]  r;
   int          fail_count = 0, checked = 0, pw_seen = 0, n, k;

   port_traffic_perf_monitor port_traffic_perf_monitor_i (
      .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
      .rd_i(rd_s), .rdata_o(rdata_o), .tx_word_i(txw), .tx_pkt_done_i(txd),
      .tx_pkt_retry_i(txr), .tx_pkt_prio_i(txp), .rx_word_i(rxw), .rx_pkt_done_i(rxd),
      .rx_pkt_retry_i(rxr), .rx_pkt_prio_i(rxp), .tx_queue_depth_i(txq),
      .rx_queue_depth_i(rxq), .reorder_i(reo), .irq_o(irq_o), .port_write_o(port_write_o),
      .tx_congested_o(tx_congested_o), .rx_congested_o(rx_congested_o));

   // ------------------------------------------
   // Shared tasks
   // ------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic complete_run();
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Gap cycle after each access keeps one assignment per time step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a; wdata <= d; wr_s <= 1'b1;
      @(posedge clk_i);
      wr_s <= 1'b0;
      @(posedge clk_i);
   endtask

   // Expected value noted now, compared by the watcher a cycle later
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ev);
      addr <= a; rd_s <= 1'b1; txw <= ev;
      exp_q.push_back(e);
      adr_q.push_back(a);
      @(posedge clk_i);
      rd_s <= 1'b0; txw <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic tpk(input logic [1:0] pr, input logic rt);
      txd <= 1'b1; txp <= pr; txr <= rt;
      @(posedge clk_i);
      txd <= 1'b0; txr <= 1'b0;
      @(posedge clk_i);
   endtask

   // ------------------------------------------
   // Clock, read watcher, watchdog
   // ------------------------------------------
   initial forever #12.5 clk_i = ~clk_i;

   // Read data stands only in the cycle after the strobe, so sample it there
   always @(posedge clk_i) begin
      if (pend) begin
         if (exp_q.size() == 0)
            chk("queue", 32'h1, 32'h0);
         else
            chk($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(), rdata_o);
      end
      pend <= rd_s;
      if (port_write_o === 1'b1) pw_seen++;
   end

   // Hang guard: a run this long counts as a failure
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      complete_run();
   end

   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial begin
      void'($urandom(32'hB4416F37));
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(perf_mon_pkg::OFS_STAT_CTRL, perf_mon_pkg::STAT_CTRL_RST, 1'b0);
      rd(perf_mon_pkg::OFS_TX_CFG, perf_mon_pkg::WM_CFG_RST, 1'b0);
      rd(perf_mon_pkg::OFS_RX_CFG, perf_mon_pkg::WM_CFG_RST, 1'b0);
      wr(perf_mon_pkg::OFS_STATUS, 32'h0000_0007);
      rd(perf_mon_pkg::OFS_STATUS, 32'h0, 1'b0);
      rd(8'h3C, 32'h0, 1'b0);
      // Counter 0 words on tx, counter 1 packets on rx with random retries
      wr(perf_mon_pkg::OFS_STAT_CTRL, 32'h0000_0500);
      n = 0;
      k = 0;
      repeat (30) begin
         @(posedge clk_i);
         r = 3'($urandom());
         txw <= r[0]; rxd <= r[1]; rxr <= r[2]; rxp <= 2'($urandom()); rxw <= r[1];
         n += r[0];
         k += int'(r[1] & ~r[2]);
      end
      @(posedge clk_i);
      txw <= 1'b0; rxd <= 1'b0; rxr <= 1'b0; rxw <= 1'b0;
      @(posedge clk_i);
      // Raw word and packet counts only; any rate or size is software's sum
      rd(perf_mon_pkg::OFS_CNT0, 32'(n), 1'b0);
      rd(perf_mon_pkg::OFS_CNT1, 32'(k), 1'b0);
      rd(perf_mon_pkg::OFS_CNT0, 32'h0, 1'b0);
      // One packet of every priority plus a retry of the chosen one
      for (int p = 0; p < 4; p++) begin
         wr(perf_mon_pkg::OFS_STAT_CTRL, 32'h0000_0302 | 32'(p << 3));
         for (int q = 0; q < 4; q++) tpk(2'(q), 1'b0);
         tpk(2'(p), 1'b1);
         rd(perf_mon_pkg::OFS_CNT0, 32'h1, 1'b0);
      end
      // Saturation, then a clearing read that meets a word
      wr(perf_mon_pkg::OFS_STAT_CTRL, 32'h0000_0500);
      wr(perf_mon_pkg::OFS_CNT0, 32'hFFFF_FFFE);
      repeat (3) tpk(2'h0, 1'b0);
      txw <= 1'b1;
      repeat (3) @(posedge clk_i);
      txw <= 1'b0;
      @(posedge clk_i);
      rd(perf_mon_pkg::OFS_CNT0, 32'hFFFF_FFFF, 1'b1);
      rd(perf_mon_pkg::OFS_CNT0, 32'h1, 1'b0);
      // Rx watermark 5, limit 0, two-cycle ticks, event masked out
      wr(perf_mon_pkg::OFS_MASK, 32'h1);
      wr(perf_mon_pkg::OFS_RX_CFG, 32'h0001_0005);
      rxq <= 8'd6;
      repeat (6) @(posedge clk_i);
      rxq <= 8'd0;
      chk("rx_congested_o", 32'h1, 32'(rx_congested_o));
      repeat (3) @(posedge clk_i);
      chk("irq_o masked", 32'h0, 32'(irq_o));
      rd(perf_mon_pkg::OFS_RX_OCC, 32'h1, 1'b0);
      rd(perf_mon_pkg::OFS_RX_PER, 32'h3, 1'b0);
      wr(perf_mon_pkg::OFS_RX_PER, 32'h1234_5678);
      rd(perf_mon_pkg::OFS_RX_PER, 32'h1234_5678, 1'b0);
      // Tx watermark 10, limit 1, port-write on; second rise passes the limit
      wr(perf_mon_pkg::OFS_TX_CFG, 32'h0010_010A);
      rd(perf_mon_pkg::OFS_TX_CFG, 32'h0010_010A, 1'b0);
      for (int e = 5; e > 2; e -= 2) begin
         txq <= 8'd11;
         repeat (e) @(posedge clk_i);
         txq <= 8'd10;
         chk("tx_congested_o", 32'h1, 32'(tx_congested_o));
         repeat (3) @(posedge clk_i);
      end
      chk("irq_o", 32'h1, 32'(irq_o));
      chk("port_write_o", 32'h1, 32'(pw_seen));
      rd(perf_mon_pkg::OFS_TX_OCC, 32'h2, 1'b0);
      rd(perf_mon_pkg::OFS_TX_PER, 32'h8, 1'b0);
      rd(perf_mon_pkg::OFS_STATUS, 32'h3, 1'b0);
      chk("irq_o cleared", 32'h0, 32'(irq_o));
      // Reorder threshold of three
      wr(perf_mon_pkg::OFS_MASK, 32'h4);
      wr(perf_mon_pkg::OFS_REORD_THR, 32'h3);
      repeat (3) begin
         reo <= 1'b1;
         @(posedge clk_i);
         reo <= 1'b0;
         @(posedge clk_i);
      end
      repeat (2) @(posedge clk_i);
      chk("irq_o reorder", 32'h1, 32'(irq_o));
      rd(perf_mon_pkg::OFS_REORD, 32'h3, 1'b0);
      rd(perf_mon_pkg::OFS_STATUS, 32'h4, 1'b0);
      repeat (2) @(posedge clk_i);
      chk("queue empty", 32'h0, 32'(exp_q.size()));
      complete_run();
   end
endmodule
`default_nettype wire
